// ### src/wps_pkg.sv
/*
 weld period sequencer package: register map, field positions, reset
 values, schedule defaults and timing counts.
 assumes a 20 MHz pclk.
*/
package wps_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [14:0] TICK_LAST = 15'(TICK_CYC - 1);
  // head detect: time a firing switch must be seen closed with feet open
  localparam int unsigned DETECT_MS = 5;
  localparam logic [15:0] DETECT_LAST = 16'(DETECT_MS - 1);

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNT = 12'h008;
  localparam logic [11:0] ADDR_SEL = 12'h00C;
  localparam logic [11:0] ADDR_PRESS = 12'h010;
  localparam logic [11:0] ADDR_HEAT1 = 12'h014;
  localparam logic [11:0] ADDR_COOL = 12'h018;
  localparam logic [11:0] ADDR_HEAT2 = 12'h01C;
  localparam logic [11:0] ADDR_HOLD = 12'h020;
  localparam logic [11:0] ADDR_MODE = 12'h024;

  // ==========================================================
  // ctrl fields
  localparam int CTRL_FORCE_FIRED = 0;
  localparam int CTRL_COUNT_CLR = 1;
  localparam int CTRL_REDETECT = 2;
  localparam int CTRL_VIEW = 3;
  // status fields
  localparam int ST_DETECTED = 0;
  localparam int ST_MANUAL = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_CURRENT = 3;
  localparam int ST_CLOSE = 4;
  localparam int ST_VIEW = 5;

  // ==========================================================
  // schedules and modes
  localparam int NSCHED = 16;
  localparam logic [3:0] SCHED_SLOPE = 4'h5;
  localparam logic [3:0] SCHED_BRAZE = 4'h6;
  localparam logic [3:0] SCHED_WHEEL = 4'h7;
  localparam logic [3:0] SCHED_SEAM = 4'h8;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_WHEEL = 2'h1;
  localparam logic [1:0] MODE_SEAM = 2'h2;
  localparam logic [15:0] DEF_TIME = 16'h0001;
  localparam logic [15:0] ZERO_TIME = 16'h0000;
  localparam logic [23:0] COUNT_MAX = 24'h98967F; // 9999999
  localparam logic [23:0] COUNT_RST = 24'h000000;

  // ==========================================================
  // sequence states
  typedef enum logic [2:0] {
    WPS_IDLE, WPS_PRESS, WPS_HEAT1, WPS_COOL, WPS_HEAT2, WPS_HOLD, WPS_END
  } wps_state_t;
endpackage : wps_pkg

// ### src/wps_sync.sv
/*
 two-flop synchroniser for one pin level.
 assumes the pin is asynchronous to pclk.
*/
`timescale 1ns/1ns
module wps_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic meta;
    logic level;
  } wps_sync_t;
  wps_sync_t s;
  wps_sync_t next_s;

  // ==========================================================
  // first flop feeds only the second
  always_comb begin
    next_s.meta = pin;
    next_s.level = s.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
endmodule : wps_sync

// ### src/wps_tick.sv
/*
 millisecond tick divider: one-cycle pulse every TICK_CYC clocks.
 assumes pclk at the rate in the package.
*/
`timescale 1ns/1ns
module wps_tick (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  typedef struct packed {
    logic [14:0] cnt;
    logic tick;
  } wps_tick_t;
  wps_tick_t s;
  wps_tick_t next_s;

  // ==========================================================
  // free-running divider
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == wps_pkg::TICK_LAST) begin
      next_s.cnt = 15'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 15'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule : wps_tick

// ### src/wps_top.sv
/*
 weld period sequencer: APB registers, head detection, weld timing.
 assumes firing and foot switch pins are asynchronous, active high
 when closed; an APB master on pclk.
*/
// Decided for this implementation: the register offsets and the APB register port.
// What this block does
// - manual head: current on firing close
// - force-fired air: both feet plus firing
// - non-force air: current after press expires
// - air head: hold close after current
// - manual head ignores press and hold
// - head type detected before first weld
// - seven-digit weld count readable
// - defaults preload schedules five, six, seven, eight
// - wheel mode repeats heat cool heat
// - wheel heat2 spot length, cool spacing
// - wheel manual: hold omitted entirely
// - seam: current until a start switch for the head type opens
// - zero heat intervals skipped
`timescale 1ns/1ns
module wps_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic firing_switch,
  input wire logic foot_level1,
  input wire logic foot_level2,
  output logic current_enable,
  output logic electrode_close
);
  typedef struct packed {
    logic [15:0] press;
    logic [15:0] heat1;
    logic [15:0] cool;
    logic [15:0] heat2;
    logic [15:0] hold;
    logic [1:0] mode;
  } wps_sched_t;

  typedef struct packed {
    wps_sched_t [wps_pkg::NSCHED-1:0] tab;
    logic [3:0] sel;
    logic force_fired;
    logic view;
    logic detected;
    logic manual;
    logic [15:0] det_cnt;
    wps_pkg::wps_state_t st;
    logic [15:0] tmr;
    logic [23:0] count;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cur;
    logic close;
  } wps_top_t;

  wps_top_t s;
  wps_top_t next_s;
  logic fire;
  logic foot1;
  logic foot2;
  logic tick;
  wps_sched_t cs;

  // ==========================================================
  // pin synchronisers and tick
  wps_sync u_sync_fire (.pclk(pclk), .presetn(presetn),
    .pin(firing_switch), .level(fire));
  wps_sync u_sync_f1 (.pclk(pclk), .presetn(presetn),
    .pin(foot_level1), .level(foot1));
  wps_sync u_sync_f2 (.pclk(pclk), .presetn(presetn),
    .pin(foot_level2), .level(foot2));
  wps_tick u_tick (.pclk(pclk), .presetn(presetn), .tick(tick));

  // factory schedule table, built once
  function automatic wps_sched_t def_sched(input int i);
    wps_sched_t d;
    d = '{wps_pkg::ZERO_TIME, wps_pkg::DEF_TIME, wps_pkg::ZERO_TIME,
          wps_pkg::ZERO_TIME, wps_pkg::ZERO_TIME, wps_pkg::MODE_SINGLE};
    if (4'(i) == wps_pkg::SCHED_SLOPE) begin
      d.heat2 = wps_pkg::DEF_TIME;
    end else if (4'(i) == wps_pkg::SCHED_BRAZE) begin
      d.hold = wps_pkg::DEF_TIME;
    end else if (4'(i) == wps_pkg::SCHED_WHEEL) begin
      d.cool = wps_pkg::DEF_TIME;
      d.heat2 = wps_pkg::DEF_TIME;
      d.mode = wps_pkg::MODE_WHEEL;
    end else if (4'(i) == wps_pkg::SCHED_SEAM) begin
      d.mode = wps_pkg::MODE_SEAM;
    end
    return d;
  endfunction : def_sched

  // next interval after a finished one, zero lengths skipped
  function automatic wps_pkg::wps_state_t after(
      input wps_pkg::wps_state_t from, input wps_sched_t c,
      input logic man);
    wps_pkg::wps_state_t n;
    n = wps_pkg::WPS_END;
    case (from)
      wps_pkg::WPS_IDLE, wps_pkg::WPS_PRESS: begin
        if (c.heat1 != 16'h0000) n = wps_pkg::WPS_HEAT1;
        else if (c.cool != 16'h0000) n = wps_pkg::WPS_COOL;
        else if (c.heat2 != 16'h0000) n = wps_pkg::WPS_HEAT2;
        else if (!man && c.hold != 16'h0000) n = wps_pkg::WPS_HOLD;
      end
      wps_pkg::WPS_HEAT1: begin
        if (c.cool != 16'h0000) n = wps_pkg::WPS_COOL;
        else if (c.heat2 != 16'h0000) n = wps_pkg::WPS_HEAT2;
        else if (!man && c.hold != 16'h0000) n = wps_pkg::WPS_HOLD;
      end
      wps_pkg::WPS_COOL: begin
        if (c.heat2 != 16'h0000) n = wps_pkg::WPS_HEAT2;
        else if (!man && c.hold != 16'h0000) n = wps_pkg::WPS_HOLD;
      end
      wps_pkg::WPS_HEAT2: begin
        if (!man && c.hold != 16'h0000) n = wps_pkg::WPS_HOLD;
      end
      default: n = wps_pkg::WPS_END;
    endcase
    return n;
  endfunction : after

  function automatic logic [15:0] len(input wps_pkg::wps_state_t st,
      input wps_sched_t c);
    case (st)
      wps_pkg::WPS_PRESS: len = c.press;
      wps_pkg::WPS_HEAT1: len = c.heat1;
      wps_pkg::WPS_COOL: len = c.cool;
      wps_pkg::WPS_HEAT2: len = c.heat2;
      wps_pkg::WPS_HOLD: len = c.hold;
      default: len = 16'h0000;
    endcase
  endfunction : len

  logic feet;
  logic start_ok;
  logic hold_sw;
  logic wr;
  logic rd;
  logic [15:0] ow;
  wps_pkg::wps_state_t nx;

  assign cs = s.tab[s.sel];
  assign feet = foot1 && foot2;
  assign ow = pwdata[15:0];

  // ==========================================================
  // next-state logic
  always_comb begin
    next_s = s;
    start_ok = 1'b0;
    hold_sw = 1'b0;
    nx = wps_pkg::WPS_END;
    wr = psel && penable && pwrite && !s.pready;
    rd = psel && penable && !pwrite && !s.pready;
    next_s.pready = psel && penable && !s.pready;
    next_s.pslverr = 1'b0;
    next_s.prdata = 32'h00000000;

    // head detection: firing seen without feet means manual
    if (!s.detected && s.st == wps_pkg::WPS_IDLE) begin
      if (feet) begin
        next_s.detected = 1'b1;
        next_s.manual = 1'b0;
      end else if (fire) begin
        next_s.det_cnt = s.det_cnt + 16'h0001;
        if (s.det_cnt == wps_pkg::DETECT_LAST) begin
          next_s.detected = 1'b1;
          next_s.manual = 1'b1;
        end
      end else begin
        next_s.det_cnt = 16'h0000;
      end
    end

    // start condition by head type
    if (s.manual) begin
      start_ok = fire;
      hold_sw = fire;
    end else if (s.force_fired) begin
      start_ok = feet && fire;
      hold_sw = feet && fire;
    end else begin
      start_ok = feet;
      hold_sw = feet;
    end

    // ==========================================================
    // sequencer
    case (s.st)
      wps_pkg::WPS_IDLE: begin
        if (s.detected && start_ok) begin
          if (!s.manual && !s.force_fired && cs.press != 16'h0000) begin
            nx = wps_pkg::WPS_PRESS;
          end else begin
            nx = after(wps_pkg::WPS_IDLE, cs, s.manual);
          end
          next_s.st = nx;
          next_s.tmr = len(nx, cs);
        end
      end
      wps_pkg::WPS_END: begin
        // wait for release before re-arming
        if (!start_ok && !fire && !feet) next_s.st = wps_pkg::WPS_IDLE;
      end
      default: begin
        if (cs.mode == wps_pkg::MODE_SEAM &&
            (s.st == wps_pkg::WPS_HEAT1)) begin
          // seam runs while the start switches for the head type stay closed
          if (!hold_sw) begin
            nx = after(wps_pkg::WPS_HEAT2, cs, s.manual);
            next_s.st = nx;
            next_s.tmr = len(nx, cs);
          end
        end else if (s.st != wps_pkg::WPS_HOLD &&
            cs.mode == wps_pkg::MODE_WHEEL && !hold_sw) begin
          // wheel stops when a switch opens
          nx = after(wps_pkg::WPS_HEAT2, cs, s.manual);
          next_s.st = nx;
          next_s.tmr = len(nx, cs);
        end else if (tick) begin
          if (s.tmr > 16'h0001) begin
            next_s.tmr = s.tmr - 16'h0001;
          end else begin
            nx = after(s.st, cs, s.manual);
            // wheel loops heat2 back to heat1
            if (cs.mode == wps_pkg::MODE_WHEEL &&
                s.st == wps_pkg::WPS_HEAT2 && hold_sw) begin
              nx = after(wps_pkg::WPS_IDLE, cs, s.manual);
            end
            next_s.st = nx;
            next_s.tmr = len(nx, cs);
          end
        end
      end
    endcase

    if (s.st != wps_pkg::WPS_END && s.st != wps_pkg::WPS_IDLE &&
        next_s.st == wps_pkg::WPS_END) begin
      next_s.count = (s.count == wps_pkg::COUNT_MAX) ?
        wps_pkg::COUNT_RST : s.count + 24'h000001;
    end

    // ==========================================================
    // register writes; timing changes take effect even while busy
    if (wr) begin
      case (paddr)
        wps_pkg::ADDR_CTRL: begin
          next_s.force_fired = pwdata[wps_pkg::CTRL_FORCE_FIRED];
          next_s.view = pwdata[wps_pkg::CTRL_VIEW];
          if (pwdata[wps_pkg::CTRL_COUNT_CLR]) begin
            next_s.count = wps_pkg::COUNT_RST;
          end
          if (pwdata[wps_pkg::CTRL_REDETECT]) begin
            next_s.detected = 1'b0;
            next_s.det_cnt = 16'h0000;
          end
        end
        wps_pkg::ADDR_SEL: next_s.sel = pwdata[3:0];
        // press and hold not programmable on manual head
        wps_pkg::ADDR_PRESS: if (!s.manual) next_s.tab[s.sel].press = ow;
        wps_pkg::ADDR_HEAT1: next_s.tab[s.sel].heat1 = ow;
        wps_pkg::ADDR_COOL: next_s.tab[s.sel].cool = ow;
        wps_pkg::ADDR_HEAT2: next_s.tab[s.sel].heat2 = ow;
        wps_pkg::ADDR_HOLD: if (!s.manual) next_s.tab[s.sel].hold = ow;
        wps_pkg::ADDR_MODE: next_s.tab[s.sel].mode = pwdata[1:0];
        wps_pkg::ADDR_STATUS, wps_pkg::ADDR_COUNT: begin
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end

    // register reads; manual head shows press and hold as zero
    if (rd) begin
      case (paddr)
        wps_pkg::ADDR_CTRL: begin
          next_s.prdata[wps_pkg::CTRL_FORCE_FIRED] = s.force_fired;
          next_s.prdata[wps_pkg::CTRL_VIEW] = s.view;
        end
        wps_pkg::ADDR_STATUS: begin
          next_s.prdata[wps_pkg::ST_DETECTED] = s.detected;
          next_s.prdata[wps_pkg::ST_MANUAL] = s.manual;
          next_s.prdata[wps_pkg::ST_BUSY] = s.st != wps_pkg::WPS_IDLE;
          next_s.prdata[wps_pkg::ST_CURRENT] = s.cur;
          next_s.prdata[wps_pkg::ST_CLOSE] = s.close;
          next_s.prdata[wps_pkg::ST_VIEW] = s.view;
        end
        wps_pkg::ADDR_COUNT: next_s.prdata[23:0] = s.count;
        wps_pkg::ADDR_SEL: next_s.prdata[3:0] = s.sel;
        wps_pkg::ADDR_PRESS:
          next_s.prdata[15:0] = s.manual ? 16'h0000 : cs.press;
        wps_pkg::ADDR_HEAT1: next_s.prdata[15:0] = cs.heat1;
        wps_pkg::ADDR_COOL: next_s.prdata[15:0] = cs.cool;
        wps_pkg::ADDR_HEAT2: next_s.prdata[15:0] = cs.heat2;
        wps_pkg::ADDR_HOLD:
          next_s.prdata[15:0] = s.manual ? 16'h0000 : cs.hold;
        wps_pkg::ADDR_MODE: next_s.prdata[1:0] = cs.mode;
        default: next_s.pslverr = 1'b1;
      endcase
    end

    // outputs follow the next state
    next_s.cur = next_s.st == wps_pkg::WPS_HEAT1 ||
                 next_s.st == wps_pkg::WPS_HEAT2;
    next_s.close = !next_s.manual &&
      (next_s.st != wps_pkg::WPS_IDLE && next_s.st != wps_pkg::WPS_END);
  end

  // ==========================================================
  // state register; table loads factory values at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      for (int i = 0; i < wps_pkg::NSCHED; i++) begin
        s.tab[i] <= def_sched(i);
      end
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign current_enable = s.cur;
  assign electrode_close = s.close;

  // ==========================================================
  // checks, all on pclk and quiet while in reset
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence fire_seen;
    s.detected && s.manual && s.st == wps_pkg::WPS_IDLE && fire;
  endsequence

  a_manual_fire: assert property (
    (fire_seen and (cs.heat1 != 16'h0000)) |=> current_enable)
    else $error("manual head did not start current");
  a_forced_needs: assert property (
    $rose(current_enable) && !s.manual && s.force_fired &&
    $past(s.st) == wps_pkg::WPS_IDLE |-> $past(feet && fire))
    else $error("forced head fired without both switches");
  a_press_first: assert property (
    s.st == wps_pkg::WPS_PRESS |-> !current_enable)
    else $error("current during press");
  a_hold_close: assert property (
    s.st == wps_pkg::WPS_HOLD |-> electrode_close && !current_enable)
    else $error("hold lost electrode close");
  a_manual_nohold: assert property (
    s.manual |-> s.st != wps_pkg::WPS_HOLD && s.st != wps_pkg::WPS_PRESS)
    else $error("manual head entered press or hold");
  a_detect_first: assert property (
    current_enable |-> s.detected)
    else $error("weld before head detection");
  a_count_wrap: assert property (
    s.count <= wps_pkg::COUNT_MAX)
    else $error("count beyond seven digits");
  a_seam_stop: assert property (
    s.st == wps_pkg::WPS_HEAT1 && cs.mode == wps_pkg::MODE_SEAM &&
    !hold_sw && !wr |=> !current_enable)
    else $error("seam current after switch open");
  a_zero_skip: assert property (
    s.st != wps_pkg::WPS_IDLE && s.st != wps_pkg::WPS_END &&
    $changed(s.st) |-> s.tmr != 16'h0000)
    else $error("zero interval entered");
endmodule : wps_top

// ### dv/wps_head_model.sv
/*
 far-side model: weld head firing switch and two-level foot switch.
 assumes the bench asks for pedal and firing levels on pclk edges.
*/
`timescale 1ns/1ns
module wps_head_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic want_feet,
  input wire logic want_fire,
  input wire logic [3:0] lag,
  output logic firing_switch,
  output logic foot_level1,
  output logic foot_level2
);
  logic [3:0] cnt;
  // ==========================================================
  // pedal: level one makes first, level two after lag cycles;
  // a slow pedal (large lag) shows the two levels apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      foot_level1 <= 1'b0;
      foot_level2 <= 1'b0;
      firing_switch <= 1'b0;
    end else begin
      firing_switch <= want_fire;
      foot_level1 <= want_feet;
      if (!want_feet) begin
        cnt <= 4'h0;
        foot_level2 <= 1'b0; // level two opens with the pedal
      end else if (cnt < lag) begin
        cnt <= cnt + 4'h1;
      end else begin
        foot_level2 <= 1'b1;
      end
    end
  end
endmodule : wps_head_model

// ### dv/wps_top_tb.sv
/*
 self-checking bench for the weld period sequencer: APB master,
 head model, register, seam and press/hold scenarios.
 assumes the design package and a 20 MHz pclk.
*/
`timescale 1ns/1ns
module wps_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic firing_switch, foot_level1, foot_level2;
  logic current_enable, electrode_close, want_feet, want_fire, e;
  int err_total, n_checks, t;

  wps_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .firing_switch(firing_switch), .foot_level1(foot_level1),
    .foot_level2(foot_level2), .current_enable(current_enable),
    .electrode_close(electrode_close));
  wps_head_model head (.pclk(pclk), .presetn(presetn),
    .want_feet(want_feet), .want_fire(want_fire), .lag(4'h3),
    .firing_switch(firing_switch), .foot_level1(foot_level1),
    .foot_level2(foot_level2));

  // ==========================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h want %h", $time, what,
        seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // apb master: held until pready is seen at a rising edge; an idle
  // cycle follows so no signal is assigned twice in one time step
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rq, output logic re);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rq = prdata;
    re = pslverr;
    if (n >= 20) check(32'h0, 32'h1, "pready never came");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dq;
    logic de;
    apb(1'b1, a, d, dq, de);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] rq);
    logic de;
    apb(1'b0, a, 32'h0, rq, de);
  endtask : rd

  // bounded wait for an output level; which 0 current, 1 close
  task automatic wait_out(input int which, input logic v, input int lim,
      output int took);
    took = 0;
    while (((which == 0) ? current_enable : electrode_close) !== v
        && took < lim) begin
      @(posedge pclk);
      took++;
    end
  endtask : wait_out

  // ==========================================================
  // factory defaults, counter reset value, map edges
  task automatic t_regs();
    rd(wps_pkg::ADDR_COUNT, q);
    check(q, 32'h0, "count at reset");
    rd(wps_pkg::ADDR_STATUS, q);
    check(q, 32'h0, "status at reset");
    wr(wps_pkg::ADDR_SEL, {28'h0, wps_pkg::SCHED_SLOPE});
    rd(wps_pkg::ADDR_HEAT2, q);
    check(q, {16'h0, wps_pkg::DEF_TIME}, "slope heat2");
    // braze ships with a hold for the alloy
    wr(wps_pkg::ADDR_SEL, {28'h0, wps_pkg::SCHED_BRAZE});
    rd(wps_pkg::ADDR_HOLD, q);
    check(q, {16'h0, wps_pkg::DEF_TIME}, "braze hold");
    // heat levels lie outside; only wheel timing here
    wr(wps_pkg::ADDR_SEL, {28'h0, wps_pkg::SCHED_WHEEL});
    rd(wps_pkg::ADDR_MODE, q);
    check(q, {30'h0, wps_pkg::MODE_WHEEL}, "wheel mode");
    rd(wps_pkg::ADDR_COOL, q);
    check(q, {16'h0, wps_pkg::DEF_TIME}, "wheel cool");
    apb(1'b0, 12'h040, 32'h0, q, e);
    check({31'h0, e}, 32'h1, "unmapped error");
    $display("test regs done");
  endtask : t_regs

  // ==========================================================
  // force-fired air head in seam mode: pedal alone gives no current
  task automatic t_seam();
    wr(wps_pkg::ADDR_CTRL, 32'h1);
    wr(wps_pkg::ADDR_SEL, {28'h0, wps_pkg::SCHED_SEAM});
    want_feet <= 1'b1;
    repeat (200) @(posedge pclk);
    check({31'h0, current_enable}, 32'h0, "no fire no current");
    rd(wps_pkg::ADDR_STATUS, q);
    check({30'h0, q[1:0]}, 32'h1, "air head detected");
    want_fire <= 1'b1;
    wait_out(0, 1'b1, 10, t);
    check({31'h0, t < 10}, 32'h1, "current on fire");
    // seam current outlasts the one-ms heat interval
    repeat (22000) @(posedge pclk);
    check({31'h0, current_enable}, 32'h1, "seam still on");
    want_fire <= 1'b0;
    wait_out(0, 1'b0, 10, t);
    check({31'h0, t < 10}, 32'h1, "seam off on open");
    want_feet <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(wps_pkg::ADDR_COUNT, q);
    check(q, 32'h1, "one weld counted");
    $display("test seam done");
  endtask : t_seam

  // ==========================================================
  // non-force air head: close first, current after press, then hold
  task automatic t_press();
    wr(wps_pkg::ADDR_CTRL, 32'h0);
    wr(wps_pkg::ADDR_SEL, 32'h0);
    // nonzero press for an air head
    wr(wps_pkg::ADDR_PRESS, 32'h1);
    wr(wps_pkg::ADDR_HOLD, 32'h1);
    want_feet <= 1'b1;
    wait_out(1, 1'b1, 10, t);
    check({31'h0, t < 10}, 32'h1, "close on pedal");
    check({31'h0, current_enable}, 32'h0, "press no current");
    wait_out(0, 1'b1, 20100, t);
    check({31'h0, t < 20100}, 32'h1, "current after press");
    wait_out(0, 1'b0, 20100, t);
    check({31'h0, t > 19990 && t < 20010}, 32'h1, "heat one ms");
    check({31'h0, electrode_close}, 32'h1, "hold keeps close");
    wait_out(1, 1'b0, 20100, t);
    check({31'h0, t > 19990 && t < 20010}, 32'h1, "hold one ms");
    want_feet <= 1'b0;
    repeat (20) @(posedge pclk);
    wr(wps_pkg::ADDR_COUNT, 32'h5);
    rd(wps_pkg::ADDR_COUNT, q);
    check(q, 32'h2, "second weld counted");
    wr(wps_pkg::ADDR_CTRL, 32'h2);
    rd(wps_pkg::ADDR_COUNT, q);
    check(q, 32'h0, "count cleared");
    $display("test press done");
  endtask : t_press

  // ==========================================================
  // manual head after redetect, on the seam schedule
  task automatic t_manual();
    wr(wps_pkg::ADDR_SEL, {28'h0, wps_pkg::SCHED_SEAM});
    wr(wps_pkg::ADDR_CTRL, 32'hC);
    want_fire <= 1'b1;
    wait_out(0, 1'b1, 20, t);
    check({31'h0, t < 20}, 32'h1, "manual fire current");
    check({31'h0, electrode_close}, 32'h0, "manual no close");
    rd(wps_pkg::ADDR_STATUS, q);
    check(q, 32'h2F, "manual status");
    want_fire <= 1'b0;
    wait_out(0, 1'b0, 10, t);
    check({31'h0, t < 10}, 32'h1, "manual seam off");
    repeat (10) @(posedge pclk);
    rd(wps_pkg::ADDR_COUNT, q);
    check(q, 32'h1, "manual weld counted");
    wr(wps_pkg::ADDR_SEL, 32'h0);
    rd(wps_pkg::ADDR_PRESS, q);
    check(q, 32'h0, "manual press hidden");
    rd(wps_pkg::ADDR_HOLD, q);
    check(q, 32'h0, "manual hold hidden");
    $display("test manual done");
  endtask : t_manual

  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // the four tests take at most about 83000 cycles
  initial begin
    repeat (95000) @(posedge pclk);
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    err_total = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    want_feet = 1'b0;
    want_fire = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_seam();
    t_press();
    t_manual();
    complete_run();
  end
endmodule : wps_top_tb
